//--- ssc_pkg.sv
// Shared constants and types of the sensor control and status bank
package ssc_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] SSC_ADDR_ACC_X_HI = 8'h01;
  localparam logic [7:0] SSC_ADDR_ACC_Z_LO = 8'h06;
  localparam logic [7:0] SSC_ADDR_INT_SRC  = 8'h0C;
  localparam logic [7:0] SSC_ADDR_DEV_ID   = 8'h0D;
  localparam logic [7:0] SSC_ADDR_CTRL1    = 8'h2A;
  localparam logic [7:0] SSC_ADDR_MAG_X_HI = 8'h40;
  localparam logic [7:0] SSC_ADDR_MAG_Z_LO = 8'h45;

  // ==========================================================
  // Reset values and identity
  localparam logic [7:0] SSC_CTRL1_RST   = 8'h08;
  localparam logic [7:0] SSC_INT_SRC_RST = 8'h00;
  // Identity values are arbitrary
  localparam logic [7:0] SSC_ID_PROD     = 8'hA7;
  localparam logic [7:0] SSC_ID_PREPROD  = 8'hA4;

  // ==========================================================
  // Timing: fastest rate period, clock rate, derived cycles
  localparam int unsigned SSC_CLK_MHZ         = 200;
  localparam int unsigned SSC_BASE_PERIOD_US  = 1250;
  localparam int unsigned SSC_BASE_PERIOD_CYC =
    SSC_BASE_PERIOD_US * SSC_CLK_MHZ;
  // Period multipliers as left shifts of the base period
  localparam logic [7:0][3:0] SSC_ODR_SHIFT =
    {4'd9, 4'd7, 4'd6, 4'd4, 4'd3, 4'd2, 4'd1, 4'd0};
  localparam logic [3:0][3:0] SSC_SLP_SHIFT =
    {4'd9, 4'd7, 4'd6, 4'd4};
  localparam logic [3:0] SSC_HYB_SHIFT = 4'd1;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    SSC_MODE_ACC = 2'b00,
    SSC_MODE_MAG = 2'b01,
    SSC_MODE_RSV = 2'b10,
    SSC_MODE_HYB = 2'b11
  } ssc_mode_e;

  typedef struct packed {
    logic [1:0] aslpRate;
    logic [2:0] dataRateField;
    logic       lowNoise;
    logic       fastRead;
    logic       active;
  } ssc_ctrl_s;

  typedef struct packed {
    logic aslp;
    logic fifo;
    logic trans;
    logic orient;
    logic pulse;
    logic ffmt;
    logic aVecm;
    logic drdy;
  } ssc_int_src_s;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } ssc_axes_s;

  typedef struct packed {
    logic       start;
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ssc_reg_req_s;

  typedef struct packed {
    logic orientNew;
    logic orientIntEn;
    logic orientSrcRead;
    logic pulseEa;
    logic pulseIntEn;
    logic pulseSrcRead;
    logic ffmtEa;
    logic ffmtIntEn;
    logic ffmtSrcRead;
    logic aVecmEvent;
    logic accelNew;
    logic magNew;
  } ssc_evt_s;

endpackage

//--- ssc_rate_tick.sv
// Divider that gives one enable pulse per output data period
`timescale 1ns/10ps
`default_nettype none

module ssc_rate_tick #(
  parameter int unsigned BASE_CYC = ssc_pkg::SSC_BASE_PERIOD_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Rate selection
  input  wire logic       run,
  input  wire logic [3:0] shift,
  // Rate enable
  output logic            tick_q
);
  import ssc_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } ssc_tick_state_s;

  ssc_tick_state_s st_q;
  ssc_tick_state_s st_d;
  logic [31:0]     limit;

  // Period in cycles is the base period shifted
  always_comb begin
    limit = (32'(BASE_CYC) << shift) - 32'h0000_0001;
    st_d  = st_q;
    st_d.tick = 1'b0;
    if (!run) begin
      st_d.cnt = 32'h0000_0000;
    end else if (st_q.cnt >= limit) begin
      st_d.cnt  = 32'h0000_0000;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 32'h0000_0001;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick_q = st_q.tick;

endmodule

`default_nettype wire

//--- ssc_int_status.sv
// Control, identity and interrupt source registers of the sensor
//
// What this block does
// - Orientation change sets flag; orientation read clears
// - Pulse event sets flag; pulse source read clears
// - Freefall/motion event sets flag; its read clears
// - Vector-magnitude flag clears on source register read
// - Data-ready set by new data per mode
// - Data-ready cleared by output read per mode
// - Hybrid auto-increment burst returns twelve bytes
// - Fixed identity register tells preproduction from production
// - Active bit selects standby or active, resets zero
// - Sleep-rate field selects sleep sampling frequency
// - Auto-sleep rate overrides the system data rate
// - Hybrid mode halves the sleep sampling rate
// - Data-rate field selects rate, resets to 001
// - Hybrid mode halves the selected data rate
// - Low-noise mode limits measurable range to 4 g
// - Fast read gives high bytes, skips low, except magnetic reads outside hybrid auto-increment
// - Fast hybrid burst returns six high bytes
// - Source register read clears only vector-magnitude flag
`timescale 1ns/10ps
`default_nettype none

module ssc_int_status #(
  parameter int unsigned BASE_CYC   = ssc_pkg::SSC_BASE_PERIOD_CYC,
  parameter bit          IS_PREPROD = 1'b0
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // Register port
  input  wire ssc_pkg::ssc_reg_req_s regReq,
  output logic [7:0]                rdData_q,
  output logic                      rdValid_q,
  output logic [7:0]                regPtr_q,
  // Engine events and source register reads
  input  wire ssc_pkg::ssc_evt_s    evt,
  // Sensor configuration and state
  input  wire ssc_pkg::ssc_mode_e   sensorMode,
  input  wire logic                 hybAutoInc,
  input  wire logic                 autoSleep,
  // Sample data for the output registers
  input  wire ssc_pkg::ssc_axes_s   accelData,
  input  wire ssc_pkg::ssc_axes_s   magData,
  // Flags and controls
  output ssc_pkg::ssc_int_src_s     intSrc_q,
  output ssc_pkg::ssc_ctrl_s        ctrl_q,
  output logic                      active_q,
  output logic                      fastRead_q,
  output logic                      rangeLimit4g_q,
  output logic [3:0]                rateShift_q,
  output logic                      odrTick_q
);
  import ssc_pkg::*;

  // ==========================================================
  // State of the block
  typedef struct packed {
    ssc_int_src_s src;
    ssc_ctrl_s    ctrl;
    logic [7:0]   ptr;
    logic [7:0]   rdData;
    logic         rdValid;
    logic [3:0]   shift;
  } ssc_state_s;

  ssc_state_s st_q;
  ssc_state_s st_d;

  // ==========================================================
  // Helpers

  // Byte of a three-axis sample, high byte first per axis
  function automatic logic [7:0] axisByte(
    input ssc_axes_s a,
    input logic [2:0] idx
  );
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      3'd0:    b = a.x[15:8];
      3'd1:    b = a.x[7:0];
      3'd2:    b = a.y[15:8];
      3'd3:    b = a.y[7:0];
      3'd4:    b = a.z[15:8];
      3'd5:    b = a.z[7:0];
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // Burst pointer step, skipping low bytes and chaining sensors
  function automatic logic [7:0] nextPtr(
    input logic [7:0] p,
    input logic       fast,
    input logic       chain
  );
    logic [7:0] n;
    logic [7:0] step;
    logic       inAcc;
    logic       inMag;
    inAcc = (p >= SSC_ADDR_ACC_X_HI) && (p <= SSC_ADDR_ACC_Z_LO);
    inMag = (p >= SSC_ADDR_MAG_X_HI) && (p <= SSC_ADDR_MAG_Z_LO);
    step  = ((inAcc || (inMag && chain)) && fast) ? 8'h02 : 8'h01;
    n     = p + step;
    if (chain && inAcc && (n > SSC_ADDR_ACC_Z_LO)) begin
      n = SSC_ADDR_MAG_X_HI;
    end else if (chain && inMag && (n > SSC_ADDR_MAG_Z_LO)) begin
      n = SSC_ADDR_ACC_X_HI;
    end
    return n;
  endfunction

  // ==========================================================
  // Decode of the current access
  logic       hybrid;
  logic       chain;
  logic       ptrInAcc;
  logic       ptrInMag;
  logic       rdIntSrc;
  logic       accRead;
  logic       magRead;
  logic [7:0] readByte;
  logic [7:0] idValue;
  logic [3:0] baseShift;

  // Mode, burst chaining and address windows
  always_comb begin
    hybrid   = (sensorMode == SSC_MODE_HYB);
    chain    = hybrid && hybAutoInc;
    ptrInAcc = (st_q.ptr >= SSC_ADDR_ACC_X_HI) &&
               (st_q.ptr <= SSC_ADDR_ACC_Z_LO);
    ptrInMag = (st_q.ptr >= SSC_ADDR_MAG_X_HI) &&
               (st_q.ptr <= SSC_ADDR_MAG_Z_LO);
    rdIntSrc = regReq.rd && !regReq.start &&
               (st_q.ptr == SSC_ADDR_INT_SRC);
    accRead  = regReq.rd && !regReq.start && ptrInAcc;
    magRead  = regReq.rd && !regReq.start && ptrInMag;
  end

  // Identity value fixed by build
  assign idValue = IS_PREPROD ? SSC_ID_PREPROD : SSC_ID_PROD;

  // Read data selection
  always_comb begin
    readByte = 8'h00;
    if (ptrInAcc) begin
      readByte = axisByte(accelData,
                          3'(st_q.ptr - SSC_ADDR_ACC_X_HI));
    end else if (ptrInMag) begin
      readByte = axisByte(magData,
                          3'(st_q.ptr - SSC_ADDR_MAG_X_HI));
    end else if (st_q.ptr == SSC_ADDR_INT_SRC) begin
      readByte = st_q.src;
    end else if (st_q.ptr == SSC_ADDR_DEV_ID) begin
      readByte = idValue;
    end else if (st_q.ptr == SSC_ADDR_CTRL1) begin
      readByte = st_q.ctrl;
    end
  end

  // Sampling period: auto-sleep rate overrides, hybrid doubling added in next state
  always_comb begin
    if (autoSleep) begin
      baseShift = SSC_SLP_SHIFT[st_q.ctrl.aslpRate];
    end else begin
      baseShift = SSC_ODR_SHIFT[st_q.ctrl.dataRateField];
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_d = st_q;
    st_d.rdValid = 1'b0;

    // Rate shift, doubled period in hybrid mode
    st_d.shift = hybrid ? (baseShift + SSC_HYB_SHIFT)
                        : baseShift;

    // Pointer load, read and write with auto-increment
    if (regReq.start) begin
      st_d.ptr = regReq.addr;
    end else if (regReq.rd) begin
      st_d.rdData  = readByte;
      st_d.rdValid = 1'b1;
      st_d.ptr     = nextPtr(st_q.ptr, st_q.ctrl.fastRead,
                             chain);
    end else if (regReq.wr) begin
      // Identity and source registers are read-only
      if (st_q.ptr == SSC_ADDR_CTRL1) begin
        st_d.ctrl = regReq.wdata;
      end
      st_d.ptr = nextPtr(st_q.ptr, st_q.ctrl.fastRead, chain);
    end

    // Orientation flag, set wins over clear
    st_d.src.orient = (evt.orientNew && evt.orientIntEn) ||
                      (st_q.src.orient && !evt.orientSrcRead);

    // Pulse flag, set wins over clear
    st_d.src.pulse = (evt.pulseEa && evt.pulseIntEn) ||
                     (st_q.src.pulse && !evt.pulseSrcRead);

    // Freefall/motion flag, set wins over clear
    st_d.src.ffmt = (evt.ffmtEa && evt.ffmtIntEn) ||
                    (st_q.src.ffmt && !evt.ffmtSrcRead);

    // Vector-magnitude flag, only flag this read clears
    st_d.src.aVecm = evt.aVecmEvent ||
                     (st_q.src.aVecm && !rdIntSrc);

    // Data-ready set and clear depend on sensor mode
    case (sensorMode)
      SSC_MODE_MAG: begin
        st_d.src.drdy = evt.magNew ||
                        (st_q.src.drdy && !magRead);
      end
      SSC_MODE_HYB: begin
        st_d.src.drdy = evt.accelNew || evt.magNew ||
                        (st_q.src.drdy && !magRead);
      end
      SSC_MODE_ACC: begin
        st_d.src.drdy = evt.accelNew ||
                        (st_q.src.drdy && !accRead);
      end
      default: begin
        st_d.src.drdy = evt.accelNew ||
                        (st_q.src.drdy && !accRead);
      end
    endcase

    // Flags owned by other engines stay clear here
    st_d.src.aslp  = 1'b0;
    st_d.src.fifo  = 1'b0;
    st_d.src.trans = 1'b0;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q.src     <= SSC_INT_SRC_RST;
      st_q.ctrl    <= SSC_CTRL1_RST;
      st_q.ptr     <= 8'h00;
      st_q.rdData  <= 8'h00;
      st_q.rdValid <= 1'b0;
      st_q.shift   <= 4'h0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Data-rate enable, running only while active
  ssc_rate_tick #(
    .BASE_CYC (BASE_CYC)
  ) u_rate (
    .clk    (clk),
    .rst_b  (rst_b),
    .run    (st_q.ctrl.active),
    .shift  (st_q.shift),
    .tick_q (odrTick_q)
  );

  // ==========================================================
  // Outputs straight from the state register
  assign rdData_q       = st_q.rdData;
  assign rdValid_q      = st_q.rdValid;
  assign regPtr_q       = st_q.ptr;
  assign intSrc_q       = st_q.src;
  assign ctrl_q         = st_q.ctrl;
  assign active_q       = st_q.ctrl.active;
  assign fastRead_q     = st_q.ctrl.fastRead;
  assign rangeLimit4g_q = st_q.ctrl.lowNoise;
  assign rateShift_q    = st_q.shift;

endmodule

`default_nettype wire

//--- ssc_int_status_props.sv
// Assertion checker for the sensor control and status bank
`timescale 1ns/10ps
`default_nettype none

module ssc_int_status_props
  import ssc_pkg::*;
#(
  parameter bit IS_PREPROD = 1'b0
) (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   rst_b,
  // Register port
  input wire ssc_pkg::ssc_reg_req_s  regReq,
  input wire logic [7:0]             rdData_q,
  input wire logic                   rdValid_q,
  input wire logic [7:0]             regPtr_q,
  // Events and flags
  input wire ssc_pkg::ssc_evt_s      evt,
  input wire ssc_pkg::ssc_mode_e     sensorMode,
  input wire ssc_pkg::ssc_int_src_s  intSrc_q,
  input wire ssc_pkg::ssc_ctrl_s     ctrl_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // A read taken at the pointer
  logic rdTake;
  assign rdTake = regReq.rd && !regReq.start;

  // ==========================================================
  // Register port and flags
  AST_READ_ANSWER: assert property (rdTake |=> rdValid_q)
    else $error("read left unanswered");
  AST_ORIENT_SET: assert property (
    evt.orientNew && evt.orientIntEn |=> intSrc_q.orient)
    else $error("orientation flag not set");
  AST_ORIENT_CLR: assert property (
    evt.orientSrcRead && !evt.orientNew |=> !intSrc_q.orient)
    else $error("orientation flag not cleared");
  AST_PULSE_SET: assert property (
    evt.pulseEa && evt.pulseIntEn |=> intSrc_q.pulse)
    else $error("pulse flag not set");
  AST_FFMT_SET: assert property (
    evt.ffmtEa && evt.ffmtIntEn |=> intSrc_q.ffmt)
    else $error("freefall flag not set");
  AST_VECM_CLR: assert property (
    rdTake && regPtr_q == SSC_ADDR_INT_SRC && !evt.aVecmEvent
    |=> !intSrc_q.aVecm) else $error("vector flag not cleared");
  AST_SRC_KEEP: assert property (
    rdTake && regPtr_q == SSC_ADDR_INT_SRC && intSrc_q.pulse
    && !evt.pulseSrcRead |=> intSrc_q.pulse)
    else $error("pulse flag lost on source read");
  AST_ID_VALUE: assert property (
    rdTake && regPtr_q == SSC_ADDR_DEV_ID |=> rdData_q ==
    (IS_PREPROD ? SSC_ID_PREPROD : SSC_ID_PROD))
    else $error("identity value wrong");
  AST_CTRL_RESET: assert property (
    $rose(rst_b) |-> ctrl_q == SSC_CTRL1_RST)
    else $error("control reset value wrong");
  AST_DRDY_ACC: assert property (
    sensorMode == SSC_MODE_ACC && evt.accelNew |=> intSrc_q.drdy)
    else $error("data-ready not set");
endmodule

bind ssc_int_status ssc_int_status_props #(.IS_PREPROD(IS_PREPROD))
  u_props (.clk(clk), .rst_b(rst_b), .regReq(regReq),
  .rdData_q(rdData_q), .rdValid_q(rdValid_q), .regPtr_q(regPtr_q),
  .evt(evt), .sensorMode(sensorMode), .intSrc_q(intSrc_q),
  .ctrl_q(ctrl_q));

`default_nettype wire

//--- ssc_host_model.sv
// Host processor model issuing register port requests
`timescale 1ns/10ps
`default_nettype none

module ssc_host_model
  import ssc_pkg::*;
(
  // Clock and read answer
  input wire logic           clk,
  input wire logic           rdValid_q,
  input wire logic [7:0]     rdData_q,
  // Requests
  output ssc_pkg::ssc_reg_req_s regReq
);
  initial regReq = '0;

  // Load the burst pointer; stale address is inverted
  task automatic point(input logic [7:0] a);
    @(posedge clk);
    regReq <= '{1'b1, 1'b0, 1'b0, a, 8'h00};
    @(posedge clk);
    regReq.start <= 1'b0;
    regReq.addr <= ~a;
  endtask

  // Write one byte at the pointer
  task automatic wr(input logic [7:0] d);
    @(posedge clk);
    regReq.wr <= 1'b1;
    regReq.wdata <= d;
    @(posedge clk);
    regReq.wr <= 1'b0;
    regReq.wdata <= ~d;
  endtask

  // Read one byte; answer stands one cycle
  task automatic rd(output logic [7:0] q, output logic ok);
    @(posedge clk);
    regReq.rd <= 1'b1;
    @(posedge clk);
    regReq.rd <= 1'b0;
    #1;
    ok = rdValid_q;
    q = rdData_q;
  endtask
endmodule

`default_nettype wire

//--- ssc_int_status_tb.sv
// Self-checking testbench of the sensor control and status bank
`timescale 1ns/10ps
`default_nettype none

module ssc_int_status_tb;
  import ssc_pkg::*;
  logic         clk = 1'b0;
  logic         rst_b = 1'b0;
  ssc_reg_req_s regReq;
  ssc_evt_s     evt = '0;
  ssc_mode_e    sensorMode = SSC_MODE_ACC;
  logic         hybAutoInc = 1'b0;
  logic         autoSleep = 1'b0;
  ssc_axes_s    accelData = 48'h1122_3344_5566;
  ssc_axes_s    magData = 48'h7788_99AA_BBCC;
  logic [7:0]   rdData_q, regPtr_q;
  logic         rdValid_q, active_q, fastRead_q, rangeLimit4g_q, odrTick_q;
  ssc_int_src_s intSrc_q;
  ssc_ctrl_s    ctrl_q;
  logic [3:0]   rateShift_q;
  logic [7:0]   odrSh [8] = '{0, 1, 2, 3, 4, 6, 7, 9};
  logic [7:0]   slpSh [4] = '{4, 6, 7, 9};
  int           mismatches = 0, n_tests = 0, gap, seen;

  always #2.5 clk = ~clk;

  ssc_host_model host (.clk(clk), .rdValid_q(rdValid_q),
    .rdData_q(rdData_q), .regReq(regReq));
  ssc_int_status #(.BASE_CYC(4)) uut (.clk(clk), .rst_b(rst_b),
    .regReq(regReq), .rdData_q(rdData_q), .rdValid_q(rdValid_q),
    .regPtr_q(regPtr_q), .evt(evt), .sensorMode(sensorMode),
    .hybAutoInc(hybAutoInc), .autoSleep(autoSleep),
    .accelData(accelData), .magData(magData), .intSrc_q(intSrc_q),
    .ctrl_q(ctrl_q), .active_q(active_q), .fastRead_q(fastRead_q),
    .rangeLimit4g_q(rangeLimit4g_q), .rateShift_q(rateShift_q),
    .odrTick_q(odrTick_q));

  // ==========================================================
  // Compare, access and report tasks
  task automatic check(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] exp);
    logic [7:0] q;
    logic       ok;
    host.rd(q, ok);
    check({7'h0, ok}, 8'h01);
    check(q, exp);
  endtask

  task automatic wreg(input logic [7:0] a, d);
    host.point(a);
    host.wr(d);
  endtask

  // Sample byte behind an output address, high byte first
  function automatic logic [7:0] smp(input logic [7:0] a);
    if (a >= 8'h40) return magData[8*(70-a)-1 -: 8];
    return accelData[8*(7-a)-1 -: 8];
  endfunction

  // Burst of n reads: accel, then magnetic, wrapping to the start
  task automatic burst(input int n, st, half);
    int m;
    host.point(8'h01);
    for (int i = 0; i < n; i++) begin
      m = i % (2*half);
      rdchk(smp(8'(m < half ? 1 + st*m : 64 + st*(m-half))));
    end
  endtask

  // New data sets data-ready; only the owning read clears it
  task automatic drdy_case(input ssc_mode_e m, input logic [11:0] e,
                           input logic [7:0] aKeep, aClr);
    @(posedge clk);
    sensorMode <= m;
    evt <= e;
    @(posedge clk);
    evt <= '0;
    host.point(aKeep);
    rdchk(smp(aKeep));
    check(intSrc_q, 8'h01);
    host.point(aClr);
    rdchk(smp(aClr));
    check(intSrc_q, 8'h00);
  endtask

  task automatic finish_test;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================
  // Main sequence; control writes made in standby
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    host.point(SSC_ADDR_CTRL1);
    rdchk(SSC_CTRL1_RST);
    wreg(SSC_ADDR_DEV_ID, 8'hFF);
    host.point(SSC_ADDR_DEV_ID);
    rdchk(SSC_ID_PROD);
    wreg(SSC_ADDR_INT_SRC, 8'hFF);
    @(posedge clk);
    #1 check(intSrc_q, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wreg(SSC_ADDR_CTRL1, {2'b00, i[2:0], 3'b000});
      repeat (2) @(posedge clk);
      #1 check({4'h0, rateShift_q}, odrSh[i]);
    end
    for (int j = 0; j < 4; j++) begin
      @(posedge clk);
      autoSleep <= 1'b1;
      sensorMode <= (j == 3) ? SSC_MODE_HYB : SSC_MODE_ACC;
      wreg(SSC_ADDR_CTRL1, {j[1:0], 6'h00});
      repeat (2) @(posedge clk);
      #1 check({4'h0, rateShift_q}, slpSh[j] + (j == 3));
    end
    @(posedge clk);
    autoSleep <= 1'b0;
    wreg(SSC_ADDR_CTRL1, 8'h38);
    repeat (2) @(posedge clk);
    #1 check({4'h0, rateShift_q}, 8'h0A);
    wreg(SSC_ADDR_CTRL1, 8'h06);
    @(posedge clk);
    #1 check({6'h0, rangeLimit4g_q, fastRead_q}, 8'h03);
    check(ctrl_q, 8'h06);
    @(posedge clk);
    sensorMode <= SSC_MODE_ACC;
    burst(3, 2, 3);
    check(regPtr_q, 8'h07);
    @(posedge clk);
    sensorMode <= SSC_MODE_HYB;
    hybAutoInc <= 1'b1;
    burst(7, 2, 3);
    wreg(SSC_ADDR_CTRL1, 8'h00);
    burst(13, 1, 6);
    // Set, keep on source read, clear on own read
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      evt <= 12'h800 >> (3*k);
      @(posedge clk);
      evt <= 12'hC00 >> (3*k);
      #1 check({7'h0, intSrc_q[4-k]}, 8'h00);
      @(posedge clk);
      evt <= '0;
      #1 check({7'h0, intSrc_q[4-k]}, 8'h01);
      host.point(SSC_ADDR_INT_SRC);
      rdchk(8'h10 >> k);
      check({7'h0, intSrc_q[4-k]}, 8'h01);
      @(posedge clk);
      evt <= 12'h200 >> (3*k);
      @(posedge clk);
      evt <= '0;
      #1 check({7'h0, intSrc_q[4-k]}, 8'h00);
    end
    @(posedge clk);
    evt <= 12'h004;
    @(posedge clk);
    evt <= '0;
    host.point(SSC_ADDR_INT_SRC);
    rdchk(8'h02);
    check(intSrc_q, 8'h00);
    drdy_case(SSC_MODE_ACC, 12'h002, 8'h40, 8'h01);
    drdy_case(SSC_MODE_MAG, 12'h001, 8'h01, 8'h40);
    drdy_case(SSC_MODE_HYB, 12'h002, 8'h01, 8'h40);
    drdy_case(SSC_MODE_HYB, 12'h001, 8'h01, 8'h40);
    // Active at fastest single-sensor rate: tick every 4 cycles
    @(posedge clk);
    sensorMode <= SSC_MODE_ACC;
    wreg(SSC_ADDR_CTRL1, 8'h01);
    gap = 0;
    seen = 0;
    for (int c = 0; c < 40 && seen < 2; c++) begin
      @(posedge clk);
      #1;
      if (seen == 1) gap++;
      if (odrTick_q === 1'b1) seen++;
    end
    check({7'h0, active_q}, 8'h01);
    check(8'(gap), 8'h04);
    finish_test();
  end
endmodule

`default_nettype wire
